/* File: rtl/lin_sleep_decelerating_stop_cmd.sv */
// sleep and decelerating-stop command handling with wishbone register file
`timescale 1ns/1ps
`default_nettype none

module lin_sleep_decelerating_stop_cmd (
   // clock and reset
   input  wire logic                                   clk_i,
   input  wire logic                                   rst_i,
   // wishbone slave
   input  wire stop_sleep_pkg::wb_req_t                wb_i,
   output stop_sleep_pkg::wb_rsp_t                     wb_o,
   // frames from the lin data-link layer
   input  wire stop_sleep_pkg::lin_frame_t             frame_i,
   // motion and chip status
   input  wire logic                                   moving_i,
   input  wire logic                                   vmin_reached_i,
   input  wire logic                                   halted_i,
   input  wire logic                                   two_point_reference_run_i,
   input  wire logic                                   over_temp_i,
   input  wire logic                                   wake_i,
   input  wire logic [stop_sleep_pkg::POS_W-1:0]       actual_position_i,
   // motion commands and mode
   output logic                                        sleep_o,
   output logic                                        decel_o,
   output logic                                        halt_o,
   output logic [stop_sleep_pkg::POS_W-1:0]            target_position_o
);

   //-------------------------------------------------------------------------
   // state
   //-------------------------------------------------------------------------
   typedef struct packed {
      logic                              ack;
      logic [stop_sleep_pkg::WB_DW-1:0]  rdat;
      logic [stop_sleep_pkg::ADDR_W-1:0] node_addr;
      logic [stop_sleep_pkg::ID_W-1:0]   cmd_id;
      logic [stop_sleep_pkg::POS_W-1:0]  secure_position;
      logic [stop_sleep_pkg::POS_W-1:0]  target_position;
      logic                              over_temp_q;
      logic                              ignored_stop;
      logic                              temp_stop;
      stop_sleep_pkg::sleep_st_t         sleep_st;
   } main_state_t;

   localparam main_state_t ST_RST = '{
      ack:             1'b0,
      rdat:            '0,
      node_addr:       stop_sleep_pkg::NODE_ADDR_RST,
      cmd_id:          stop_sleep_pkg::CMD_ID_RST,
      secure_position: stop_sleep_pkg::SECURE_OFF,
      target_position: stop_sleep_pkg::TGTPOS_RST,
      over_temp_q:     1'b0,
      ignored_stop:    1'b0,
      temp_stop:       1'b0,
      sleep_st:        stop_sleep_pkg::SL_AWAKE
   };

   main_state_t cur_ff;
   main_state_t nxt_st;

   //-------------------------------------------------------------------------
   // frame recognition and stop sequencer
   //-------------------------------------------------------------------------
   logic sleep_hit;
   logic stop_hit;
   logic temp_rise;
   logic ext_stop;
   logic sleep_stop;
   logic stop_start;
   logic stop_done;
   logic stop_busy;

   lin_frame_classifier u_classifier (
      .frame_i     (frame_i),
      .node_addr_i (cur_ff.node_addr),
      .cmd_id_i    (cur_ff.cmd_id),
      .sleep_hit_o (sleep_hit),
      .stop_hit_o  (stop_hit)
   );

   decel_stop_seq u_stop_seq (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .start_i        (stop_start),
      .moving_i       (moving_i),
      .vmin_reached_i (vmin_reached_i),
      .halted_i       (halted_i),
      .decel_o        (decel_o),
      .halt_o         (halt_o),
      .done_o         (stop_done)
   );

   // only a fresh over-temperature starts a stop, not a lasting one
   assign temp_rise  = over_temp_i && !cur_ff.over_temp_q;
   // external and thermal requests are dropped during a reference run
   assign ext_stop   = (stop_hit || temp_rise) && !two_point_reference_run_i;
   assign stop_start = ext_stop || sleep_stop;
   assign stop_busy  = decel_o || halt_o;

   //-------------------------------------------------------------------------
   // bus decode helpers
   //-------------------------------------------------------------------------
   logic                             bus_req;
   logic                             bus_wr;
   logic [stop_sleep_pkg::WB_DW-1:0] rd_word;
   logic [stop_sleep_pkg::WB_DW-1:0] wr_word;

   // request taken while ack is low; write committed on the acked edge
   assign bus_req = wb_i.cyc && wb_i.stb && !cur_ff.ack;
   assign bus_wr  = wb_i.cyc && wb_i.stb && wb_i.we && cur_ff.ack;

   // read mux, unmapped addresses read zero
   always_comb begin
      rd_word = '0;
      unique case (wb_i.adr)
         stop_sleep_pkg::ADR_CTRL: begin
            rd_word[stop_sleep_pkg::CTRL_ADDR_LSB +: stop_sleep_pkg::ADDR_W] = cur_ff.node_addr;
            rd_word[stop_sleep_pkg::CTRL_ID_LSB +: stop_sleep_pkg::ID_W]     = cur_ff.cmd_id;
         end
         stop_sleep_pkg::ADR_STATUS: begin
            rd_word[stop_sleep_pkg::ST_ASLEEP_BIT] = cur_ff.sleep_st == stop_sleep_pkg::SL_ASLEEP;
            rd_word[stop_sleep_pkg::ST_STOP_BIT]   = stop_busy;
            rd_word[stop_sleep_pkg::ST_PEND_BIT]   =
               cur_ff.sleep_st == stop_sleep_pkg::SL_WAIT_TARGET ||
               cur_ff.sleep_st == stop_sleep_pkg::SL_WAIT_STOP;
            rd_word[stop_sleep_pkg::ST_IGN_BIT]    = cur_ff.ignored_stop;
            rd_word[stop_sleep_pkg::ST_TEMP_BIT]   = cur_ff.temp_stop;
         end
         stop_sleep_pkg::ADR_SECURE_POSITION: begin
            rd_word[stop_sleep_pkg::POS_W-1:0] = cur_ff.secure_position;
         end
         stop_sleep_pkg::ADR_TGTPOS: begin
            rd_word[stop_sleep_pkg::POS_W-1:0] = cur_ff.target_position;
         end
         stop_sleep_pkg::ADR_ACTUAL_POSITION: begin
            rd_word[stop_sleep_pkg::POS_W-1:0] = actual_position_i;
         end
         default: rd_word = '0;
      endcase
   end

   // merged write value; reading the current word keeps unselected lanes
   assign wr_word = stop_sleep_pkg::merge_be(rd_word, wb_i.dat, wb_i.sel);

   //-------------------------------------------------------------------------
   // next-state logic
   //-------------------------------------------------------------------------
   always_comb begin
      nxt_st      = cur_ff;
      sleep_stop  = 1'b0;
      nxt_st.ack  = bus_req;
      nxt_st.over_temp_q = over_temp_i;
      if (bus_req) begin
         nxt_st.rdat = rd_word;
      end

      // software writes; hardware updates below take precedence
      if (bus_wr) begin
         unique case (wb_i.adr)
            stop_sleep_pkg::ADR_CTRL: begin
               nxt_st.node_addr =
                  wr_word[stop_sleep_pkg::CTRL_ADDR_LSB +: stop_sleep_pkg::ADDR_W];
               nxt_st.cmd_id = wr_word[stop_sleep_pkg::CTRL_ID_LSB +: stop_sleep_pkg::ID_W];
            end
            stop_sleep_pkg::ADR_STATUS: begin
               // write one to clear the sticky flags
               if (wr_word[stop_sleep_pkg::ST_IGN_BIT]) begin
                  nxt_st.ignored_stop = 1'b0;
               end
               if (wr_word[stop_sleep_pkg::ST_TEMP_BIT]) begin
                  nxt_st.temp_stop = 1'b0;
               end
            end
            stop_sleep_pkg::ADR_SECURE_POSITION: begin
               nxt_st.secure_position = wr_word[stop_sleep_pkg::POS_W-1:0];
            end
            stop_sleep_pkg::ADR_TGTPOS: begin
               nxt_st.target_position = wr_word[stop_sleep_pkg::POS_W-1:0];
            end
            default: ;
         endcase
      end

      // sticky flags: a set in the clearing cycle wins
      if ((stop_hit || temp_rise) && two_point_reference_run_i) begin
         nxt_st.ignored_stop = 1'b1;
      end
      if (temp_rise && !two_point_reference_run_i) begin
         nxt_st.temp_stop = 1'b1;
      end

      // sleep sequencing
      unique case (cur_ff.sleep_st)
         stop_sleep_pkg::SL_AWAKE: begin
            if (sleep_hit) begin
               if (!moving_i) begin
                  nxt_st.sleep_st = stop_sleep_pkg::SL_ASLEEP;
               end else if (cur_ff.secure_position != stop_sleep_pkg::SECURE_OFF) begin
                  nxt_st.target_position = cur_ff.secure_position;
                  nxt_st.sleep_st        = stop_sleep_pkg::SL_WAIT_TARGET;
               end else begin
                  sleep_stop      = 1'b1;
                  nxt_st.sleep_st = stop_sleep_pkg::SL_WAIT_STOP;
               end
            end
         end
         stop_sleep_pkg::SL_WAIT_TARGET: begin
            // the motor runs on to the secure position, then sleeps
            if (!moving_i) begin
               nxt_st.sleep_st = stop_sleep_pkg::SL_ASLEEP;
            end
         end
         stop_sleep_pkg::SL_WAIT_STOP: begin
            // motion that ended on its own must not leave us waiting forever
            if (stop_done || (!moving_i && !stop_busy)) begin
               nxt_st.sleep_st = stop_sleep_pkg::SL_ASLEEP;
            end
         end
         stop_sleep_pkg::SL_ASLEEP: begin
            if (wake_i || (bus_wr && wb_i.adr == stop_sleep_pkg::ADR_CTRL &&
                           wr_word[stop_sleep_pkg::CTRL_WAKE_BIT])) begin
               nxt_st.sleep_st = stop_sleep_pkg::SL_AWAKE;
            end
         end
      endcase

      // hold where the motor stopped; overrides any other target update
      if (stop_done) begin
         nxt_st.target_position = actual_position_i;
      end
   end

   //-------------------------------------------------------------------------
   // state register
   //-------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_ff <= ST_RST;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   //-------------------------------------------------------------------------
   // outputs
   //-------------------------------------------------------------------------
   assign wb_o              = '{ack: cur_ff.ack, dat: cur_ff.rdat};
   assign sleep_o           = cur_ff.sleep_st == stop_sleep_pkg::SL_ASLEEP;
   assign target_position_o = cur_ff.target_position;

   //-------------------------------------------------------------------------
   // assertions
   //-------------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic sleep_ok;
   assign sleep_ok = cur_ff.sleep_st == stop_sleep_pkg::SL_AWAKE && sleep_hit;

   a_sleep_still_motor: assert property (sleep_ok && !moving_i |=> sleep_o)
      else $error("sleep frame at standstill did not enter sleep");

   a_sleep_frame_form: assert property (
      sleep_hit |-> frame_i.ident == stop_sleep_pkg::SLEEP_ID &&
      frame_i.data[0] == stop_sleep_pkg::SLEEP_FIRST)
      else $error("sleep recognised on wrong identifier or first byte");

   // a long sleep frame must carry the fill pattern in its second byte
   a_sleep_fill_bytes: assert property (
      sleep_hit && frame_i.len > stop_sleep_pkg::SLEEP_MIN_LEN |->
      frame_i.data[1] == stop_sleep_pkg::SLEEP_FILL)
      else $error("sleep recognised with a bad fill byte");

   a_sleep_secure_load: assert property (
      sleep_ok && moving_i && cur_ff.secure_position != stop_sleep_pkg::SECURE_OFF |=>
      target_position_o == $past(cur_ff.secure_position) && !sleep_o)
      else $error("secure position not loaded before sleep");

   a_sleep_decel_first: assert property (
      sleep_ok && moving_i && cur_ff.secure_position == stop_sleep_pkg::SECURE_OFF |=>
      (decel_o || halt_o) && !sleep_o)
      else $error("sleep during motion without decelerating stop");

   a_ramp_then_halt: assert property (decel_o && vmin_reached_i |=> halt_o && !decel_o)
      else $error("minimum velocity reached but no halt");

   // a stop request at standstill leaves the sequencer idle
   a_stop_needs_motion: assert property (
      stop_start && !moving_i && !stop_busy |=> !decel_o && !halt_o)
      else $error("decelerating stop started without motion");

   a_halt_copy_actual: assert property (
      halt_o && halted_i |=> target_position_o == $past(actual_position_i) ##1 !halt_o)
      else $error("actual position not copied after halt");

   a_ref_run_blocks: assert property (
      !stop_busy && stop_hit && two_point_reference_run_i && !sleep_stop |=>
      !decel_o && cur_ff.ignored_stop)
      else $error("stop honoured during reference run");

   // during a reference run only a sleep may start the sequencer
   a_ref_run_silent: assert property (
      two_point_reference_run_i && !sleep_stop && !stop_busy |=> !decel_o)
      else $error("sequencer started during reference run");

   // a sticky flag set must win over a software clear in the same cycle
   a_ignore_flag_set: assert property (
      (stop_hit || temp_rise) && two_point_reference_run_i |=> cur_ff.ignored_stop)
      else $error("ignored stop not flagged");

   a_temp_triggers: assert property (
      temp_rise && !two_point_reference_run_i && moving_i && !stop_busy |=> decel_o)
      else $error("over-temperature did not start a decelerating stop");

   a_temp_flag_set: assert property (
      temp_rise && !two_point_reference_run_i |=> cur_ff.temp_stop)
      else $error("thermal stop not flagged");

   a_stop_frame_code: assert property (
      stop_hit |-> frame_i.len == stop_sleep_pkg::STOP_LEN && !frame_i.ident[5] &&
      frame_i.data[0] == {1'b1, stop_sleep_pkg::STOP_CMD})
      else $error("stop recognised on a wrong frame");

   a_broadcast_all: assert property (
      frame_i.valid && frame_i.ident == {1'b0, cur_ff.cmd_id} &&
      frame_i.len == stop_sleep_pkg::STOP_LEN &&
      frame_i.data[0] == {1'b1, stop_sleep_pkg::STOP_CMD} &&
      !frame_i.data[1][stop_sleep_pkg::BROAD_BIT] |-> stop_hit)
      else $error("broadcast stop frame not recognised");

   a_addressed_only: assert property (
      stop_hit && frame_i.data[1][stop_sleep_pkg::BROAD_BIT] |->
      frame_i.data[1][stop_sleep_pkg::ADDR_W-1:0] == cur_ff.node_addr)
      else $error("addressed stop taken for another node");

   a_bus_ack_pulse: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack ##1 !wb_o.ack)
      else $error("wishbone ack not a one-cycle answer");

   c_sleep_secure: cover property (sleep_ok && moving_i &&
      cur_ff.secure_position != stop_sleep_pkg::SECURE_OFF ##[1:50] sleep_o);
   c_sleep_decel: cover property (cur_ff.sleep_st == stop_sleep_pkg::SL_WAIT_STOP && stop_done);
   c_temp_stop: cover property (temp_rise && moving_i ##1 decel_o);
   c_addr_stop: cover property (stop_hit && frame_i.data[1][stop_sleep_pkg::BROAD_BIT]);

endmodule // lin_sleep_decelerating_stop_cmd

`default_nettype wire

/* File: rtl/stop_sleep_pkg.sv */
// constants, types and helpers shared by the sleep / decelerating-stop command block
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package stop_sleep_pkg;

   //-------------------------------------------------------------------------
   // widths
   //-------------------------------------------------------------------------
   localparam int WB_AW     = 8;
   localparam int WB_DW     = 32;
   localparam int WB_BYTES  = 4;
   localparam int BYTE_W    = 8;
   localparam int FRAME_MAX = 8;
   localparam int LEN_W     = 4;
   localparam int ADDR_W    = 7;
   localparam int ID_W      = 5;
   localparam int POS_W     = 11;

   //-------------------------------------------------------------------------
   // frame coding
   //-------------------------------------------------------------------------
   localparam logic [5:0]        SLEEP_ID      = 6'h3c;
   localparam logic [7:0]        SLEEP_FIRST   = 8'h00;
   localparam logic [7:0]        SLEEP_FILL    = 8'hff;
   localparam logic [LEN_W-1:0]  SLEEP_MIN_LEN = 4'h1;
   localparam logic [6:0]        STOP_CMD      = 7'h0f;
   localparam logic [LEN_W-1:0]  STOP_LEN      = 4'h2;
   localparam int                BROAD_BIT     = 7;
   localparam logic [POS_W-1:0]  SECURE_OFF    = 11'h400;

   //-------------------------------------------------------------------------
   // register map (byte addresses) and fields
   //-------------------------------------------------------------------------
   localparam logic [WB_AW-1:0] ADR_CTRL   = 8'h00;
   localparam logic [WB_AW-1:0] ADR_STATUS = 8'h04;
   localparam logic [WB_AW-1:0] ADR_SECURE_POSITION = 8'h08;
   localparam logic [WB_AW-1:0] ADR_TGTPOS = 8'h0c;
   localparam logic [WB_AW-1:0] ADR_ACTUAL_POSITION = 8'h10;
   localparam int CTRL_WAKE_BIT  = 0;
   localparam int CTRL_ADDR_LSB  = 8;
   localparam int CTRL_ID_LSB    = 16;
   localparam int ST_ASLEEP_BIT  = 0;
   localparam int ST_STOP_BIT    = 1;
   localparam int ST_PEND_BIT    = 2;
   localparam int ST_IGN_BIT     = 3;
   localparam int ST_TEMP_BIT    = 4;
   localparam logic [ADDR_W-1:0] NODE_ADDR_RST = 7'h00;
   localparam logic [ID_W-1:0]   CMD_ID_RST    = 5'h00;
   localparam logic [POS_W-1:0]  TGTPOS_RST    = 11'h000;

   //-------------------------------------------------------------------------
   // carriers and states
   //-------------------------------------------------------------------------
   typedef struct packed {
      logic                              valid;
      logic [5:0]                        ident;
      logic [LEN_W-1:0]                  len;
      logic [FRAME_MAX-1:0][BYTE_W-1:0]  data;   // data[0] is the first data byte
   } lin_frame_t;

   typedef struct packed {
      logic                cyc;
      logic                stb;
      logic                we;
      logic [WB_BYTES-1:0] sel;
      logic [WB_AW-1:0]    adr;
      logic [WB_DW-1:0]    dat;
   } wb_req_t;

   typedef struct packed {
      logic             ack;
      logic [WB_DW-1:0] dat;
   } wb_rsp_t;

   typedef enum logic [1:0] {SL_AWAKE, SL_WAIT_TARGET, SL_WAIT_STOP, SL_ASLEEP} sleep_st_t;
   typedef enum logic [1:0] {SS_IDLE, SS_RAMP, SS_HALT} stop_st_t;

   // byte-lane merge for a wishbone write
   function automatic logic [WB_DW-1:0] merge_be(input logic [WB_DW-1:0]    old_v,
                                                 input logic [WB_DW-1:0]    new_v,
                                                 input logic [WB_BYTES-1:0] sel);
      logic [WB_DW-1:0] r;
      r = old_v;
      for (int b = 0; b < WB_BYTES; b++) begin
         if (sel[b]) begin
            r[BYTE_W*b +: BYTE_W] = new_v[BYTE_W*b +: BYTE_W];
         end
      end
      return r;
   endfunction

endpackage

/* File: rtl/lin_frame_classifier.sv */
// combinational recognition of sleep and decelerating-stop frames
`timescale 1ns/1ps
`default_nettype none

module lin_frame_classifier (
   // received frame
   input  wire stop_sleep_pkg::lin_frame_t              frame_i,
   // node configuration
   input  wire logic [stop_sleep_pkg::ADDR_W-1:0]       node_addr_i,
   input  wire logic [stop_sleep_pkg::ID_W-1:0]         cmd_id_i,
   // hits
   output logic                                         sleep_hit_o,
   output logic                                         stop_hit_o
);

   logic fill_ok;
   logic addr_ok;

   // pattern checks; address plays no part in sleep
   always_comb begin
      fill_ok = 1'b1;
      for (int i = 1; i < stop_sleep_pkg::FRAME_MAX; i++) begin
         if (stop_sleep_pkg::LEN_W'(i) < frame_i.len &&
             frame_i.data[i] != stop_sleep_pkg::SLEEP_FILL) begin
            fill_ok = 1'b0;
         end
      end
      sleep_hit_o = frame_i.valid && frame_i.ident == stop_sleep_pkg::SLEEP_ID &&
                    frame_i.len >= stop_sleep_pkg::SLEEP_MIN_LEN &&
                    frame_i.data[0] == stop_sleep_pkg::SLEEP_FIRST && fill_ok;
      // flag clear: all nodes; flag set: own address only
      addr_ok = !frame_i.data[1][stop_sleep_pkg::BROAD_BIT] ||
                frame_i.data[1][stop_sleep_pkg::ADDR_W-1:0] == node_addr_i;
      stop_hit_o = frame_i.valid && frame_i.ident == {1'b0, cmd_id_i} &&
                   frame_i.len == stop_sleep_pkg::STOP_LEN &&
                   frame_i.data[0] == {1'b1, stop_sleep_pkg::STOP_CMD} && addr_ok;
   end

endmodule // lin_frame_classifier

`default_nettype wire

/* File: rtl/decel_stop_seq.sv */
// decelerating stop sequencer: ramp to minimum velocity, halt, report done
`timescale 1ns/1ps
`default_nettype none

module decel_stop_seq (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // request and motion feedback
   input  wire logic start_i,
   input  wire logic moving_i,
   input  wire logic vmin_reached_i,
   input  wire logic halted_i,
   // motion commands
   output logic      decel_o,
   output logic      halt_o,
   output logic      done_o
);

   typedef struct packed {
      stop_sleep_pkg::stop_st_t st;
   } seq_state_t;

   seq_state_t cur_ff;
   seq_state_t nxt_st;

   // a start while already stopping is absorbed by the running sequence
   always_comb begin
      nxt_st = cur_ff;
      unique case (cur_ff.st)
         stop_sleep_pkg::SS_IDLE: begin
            if (start_i && moving_i) begin
               nxt_st.st = stop_sleep_pkg::SS_RAMP;
            end
         end
         stop_sleep_pkg::SS_RAMP: begin
            if (vmin_reached_i) begin
               nxt_st.st = stop_sleep_pkg::SS_HALT;
            end
         end
         stop_sleep_pkg::SS_HALT: begin
            if (halted_i) begin
               nxt_st.st = stop_sleep_pkg::SS_IDLE;
            end
         end
         default: nxt_st.st = stop_sleep_pkg::SS_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_ff.st <= stop_sleep_pkg::SS_IDLE;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign decel_o = cur_ff.st == stop_sleep_pkg::SS_RAMP;
   assign halt_o  = cur_ff.st == stop_sleep_pkg::SS_HALT;
   assign done_o  = halt_o && halted_i;

endmodule // decel_stop_seq

`default_nettype wire

/* File: test/lin_master_model.sv */
// lin master model: hands one received frame per call to the node
`timescale 1ns/1ps
`default_nettype none
module lin_master_model (
   // clock
   input  wire logic                   clk_i,
   // frame towards the node
   output var stop_sleep_pkg::lin_frame_t frame_o
);
   initial frame_o = '0;
   // one-cycle frame pulse; bytes past the second carry the sleep fill
   task automatic send(input logic [5:0] id, input logic [3:0] n,
                       input logic [7:0] b0, input logic [7:0] b1);
      @(posedge clk_i);
      frame_o.ident <= id;
      frame_o.len   <= n;
      frame_o.data  <= {{6{8'hff}}, b1, b0};
      frame_o.valid <= 1'b1;
      @(posedge clk_i);
      frame_o.valid <= 1'b0;
      frame_o.data  <= ~frame_o.data; // stale bytes must not look valid
   endtask
endmodule // lin_master_model
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the sleep and decelerating-stop block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
   $display("unexpected %s exp %h got %h", n, e, s); end end
module tb;
   logic clk_i = 0, rst_i = 1, mv = 0, vm = 0, hl = 0, rr = 0, ot = 0, wk = 0;
   logic [10:0] act = 11'h2a5;
   logic [31:0] rd;
   stop_sleep_pkg::wb_req_t    wb = '0;
   stop_sleep_pkg::wb_rsp_t    wbo;
   stop_sleep_pkg::lin_frame_t fr;
   logic        sl, dc, ht;
   logic [10:0] tgt;
   int          error_cnt = 0, samples_checked = 0;
   initial forever #4 clk_i = ~clk_i;
   lin_master_model i_master (.clk_i(clk_i), .frame_o(fr));
   lin_sleep_decelerating_stop_cmd i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_o(wbo),
      .frame_i(fr), .moving_i(mv), .vmin_reached_i(vm), .halted_i(hl),
      .two_point_reference_run_i(rr), .over_temp_i(ot), .wake_i(wk),
      .actual_position_i(act), .sleep_o(sl), .decel_o(dc), .halt_o(ht),
      .target_position_o(tgt));
   task automatic final_report;
      if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // classic cycle held until ack is sampled; read data taken at that edge
   task automatic wb_cyc(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
      int n = 0;
      @(posedge clk_i);
      wb <= '{1'b1, 1'b1, w, 4'hf, a, d};
      do begin @(posedge clk_i); n++; end while (wbo.ack !== 1'b1 && n < 50);
      q = wbo.dat;
      wb <= '0;
      if (n >= 50) begin error_cnt++; final_report(); end
   endtask
   // ramp done, then halt done; target must follow the live position
   task automatic finish_stop;
      @(posedge clk_i); vm <= 1;
      @(posedge clk_i); @(negedge clk_i); `CHK("halt", 1'b1, ht)
      `CHK("decel", 1'b0, dc)
      @(posedge clk_i); vm <= 0; hl <= 1; act <= act + 11'h011;
      @(posedge clk_i); hl <= 0; mv <= 0; ot <= 0;
      @(negedge clk_i); `CHK("target", act, tgt)
   endtask
   task automatic t_stop(input logic [7:0] b1);
      @(posedge clk_i); mv <= 1;
      i_master.send(6'h00, 4'h2, 8'h8f, b1);
      @(negedge clk_i); `CHK("decel", 1'b1, dc)
      finish_stop();
   endtask
   // refused stop: wrong address or reference run in progress
   task automatic t_no_stop(input logic [7:0] b1, input logic ref_run);
      @(posedge clk_i); mv <= 1; rr <= ref_run;
      i_master.send(6'h00, 4'h2, 8'h8f, b1);
      @(negedge clk_i); `CHK("decel", 1'b0, dc)
      @(posedge clk_i); rr <= 0; mv <= 0;
   endtask
   task automatic t_therm;
      @(posedge clk_i); mv <= 1; ot <= 1;
      @(posedge clk_i); @(negedge clk_i); `CHK("decel", 1'b1, dc)
      finish_stop();
   endtask
   task automatic wake;
      @(posedge clk_i); wk <= 1;
      @(posedge clk_i); wk <= 0;
   endtask
   task automatic t_sleep;
      i_master.send(6'h3c, 4'h3, 8'h00, 8'hfe);
      @(negedge clk_i); `CHK("sleep", 1'b0, sl)
      i_master.send(6'h3c, 4'h3, 8'h00, 8'hff);
      @(negedge clk_i); `CHK("sleep", 1'b1, sl)
      wake();
      wb_cyc(1'b1, 8'h08, 32'h123, rd); mv <= 1;
      i_master.send(6'h3c, 4'h2, 8'h00, 8'hff);
      @(negedge clk_i); `CHK("target", 11'h123, tgt)
      @(posedge clk_i); mv <= 0;
      @(posedge clk_i); @(negedge clk_i); `CHK("sleep", 1'b1, sl)
      wake();
      wb_cyc(1'b1, 8'h08, 32'h400, rd); mv <= 1;
      i_master.send(6'h3c, 4'h2, 8'h00, 8'hff);
      @(negedge clk_i); `CHK("decel", 1'b1, dc)
      finish_stop();
      @(posedge clk_i); @(negedge clk_i); `CHK("sleep", 1'b1, sl)
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      @(negedge clk_i); `CHK("target", 11'h000, tgt)
      `CHK("halt", 1'b0, ht)
      wb_cyc(1'b0, 8'h08, 32'h0, rd); `CHK("secure", 32'h400, rd)
      wb_cyc(1'b0, 8'h40, 32'h0, rd); `CHK("unmapped", 32'h0, rd)
      t_stop(8'h00);
      t_no_stop(8'h85, 1'b0);
      t_no_stop(8'h00, 1'b1);
      wb_cyc(1'b0, 8'h04, 32'h0, rd); `CHK("status", 32'h8, rd)
      wb_cyc(1'b1, 8'h04, 32'h18, rd);
      wb_cyc(1'b1, 8'h00, 32'h1500, rd);
      t_stop(8'h95);
      t_therm();
      wb_cyc(1'b0, 8'h04, 32'h0, rd); `CHK("status", 32'h10, rd)
      t_sleep();
      wb_cyc(1'b0, 8'h04, 32'h0, rd); `CHK("status", 32'h11, rd)
      final_report();
   end
endmodule // tb
`default_nettype wire
